// >>> design/dsaio_consts.svh
// Constants for the short-address and full-address transfer channel.
// Assumes it is included by its bare name from the trigger selector and the channel files.
`ifndef DSAIO_CONSTS_SVH
`define DSAIO_CONSTS_SVH

// ==========================================================================
// Register indexes on the plain register port
`define DSAIO_REG_MEM_ADDR   4'h0
`define DSAIO_REG_PERIPH_LO  4'h1
`define DSAIO_REG_COUNT      4'h2
`define DSAIO_REG_CTRL       4'h3
`define DSAIO_REG_DEST_ADDR  4'h4
`define DSAIO_REG_FULL_CTRL  4'h5
`define DSAIO_REG_STATUS     4'h6

// ==========================================================================
// Channel control field positions
`define DSAIO_CTL_TE         7
`define DSAIO_CTL_SIZE       6
`define DSAIO_CTL_DIR        5
`define DSAIO_CTL_RPT        4
`define DSAIO_CTL_IRQE       3
`define DSAIO_CTL_TRIG_HI    2
`define DSAIO_CTL_TRIG_LO    0
// Full-address control field positions
`define DSAIO_FC_FULL        0
`define DSAIO_FC_BLOCK       1
`define DSAIO_FC_TMS         2
`define DSAIO_FC_SRC_HI      4
`define DSAIO_FC_SRC_LO      3
`define DSAIO_FC_DST_HI      6
`define DSAIO_FC_DST_LO      5
`define DSAIO_FC_BSZ_HI      15
`define DSAIO_FC_BSZ_LO      8

// ==========================================================================
// Reset values and fixed patterns
`define DSAIO_RST_ADDR       24'h000000
`define DSAIO_RST_PERIPH     8'h00
`define DSAIO_RST_COUNT      16'h0000
`define DSAIO_RST_CTRL       8'h00
`define DSAIO_RST_FULL_CTRL  16'h0000
`define DSAIO_PERIPH_HIGH    16'hffff
// Address step codes
`define DSAIO_STEP_HOLD      2'h0
`define DSAIO_STEP_UP        2'h1
`define DSAIO_STEP_DOWN      2'h2
// ==========================================================================
// Trigger select codes
`define DSAIO_TRG_TIMER0     3'h0
`define DSAIO_TRG_TIMER1     3'h1
`define DSAIO_TRG_TIMER2     3'h2
`define DSAIO_TRG_ADC        3'h3
`define DSAIO_TRG_SER_TX     3'h4
`define DSAIO_TRG_SER_RX     3'h5
`define DSAIO_TRG_EXT_EDGE   3'h6
`define DSAIO_TRG_EXT_LEVEL  3'h7
`define DSAIO_TRG_AUTO_BURST 3'h0
`define DSAIO_TRG_AUTO_STEAL 3'h2

`endif

// >>> design/dsaio_pkg.sv
// Types shared by the transfer channel and its trigger selector.
// Needs nothing from the constants header beside it.
`default_nettype none

package dsaio_pkg;

  // ========================================================================
  // Operating mode of the channel
  typedef enum logic [1:0] {
    DSAIO_MODE_IO,
    DSAIO_MODE_IDLE,
    DSAIO_MODE_NORMAL,
    DSAIO_MODE_BLOCK
  } dsaio_mode_type;
  // Bus sequencer states
  typedef enum logic [2:0] {
    DSAIO_ST_IDLE,
    DSAIO_ST_REQ,
    DSAIO_ST_RD,
    DSAIO_ST_WR
  } dsaio_state_type;
endpackage

`default_nettype wire

// >>> design/dsaio_trig_sel.sv
// Trigger selector: picks the activation source and says which way data moves.
// Assumes peripheral event inputs are one-cycle pulses on the same clock; the
// external request pin is asynchronous and is synchronised here.
`include "dsaio_consts.svh"
`default_nettype none

module dsaio_trig_sel (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire dsaio_pkg::dsaio_mode_type mode,
  input  wire logic [2:0]               code,
  input  wire logic [2:0]               timer_match,
  input  wire logic                     sci_tx_empty,
  input  wire logic                     sci_rx_full,
  input  wire logic                     adc_conv_end,
  input  wire logic                     ext_req_n,
  output logic                          trig_event,
  output logic                          trig_level,
  output logic                          auto_req,
  output logic                          auto_burst,
  output logic                          periph_to_mem,
  output logic                          code_ok
);
  import dsaio_pkg::*;

  // ========================================================================
  // External request synchroniser
  logic ext_s1_q;  // First stage, read only by the second
  logic ext_s2_q;  // Settled level
  logic ext_s3_q;  // Previous settled level for the edge

  // Three flops: two to settle the pin, one to find its falling edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_s3_q <= 1'b1;
    end else begin
      ext_s1_q <= ext_req_n;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  wire ext_fall = ext_s3_q & ~ext_s2_q;  // Falling edge of the request
  wire ext_low  = ~ext_s2_q;              // Request pin held low

  // ========================================================================
  // Source decode
  wire short_mode = (mode == DSAIO_MODE_IO) || (mode == DSAIO_MODE_IDLE);
  wire is_timer   = (code == `DSAIO_TRG_TIMER0) || (code == `DSAIO_TRG_TIMER1) ||
                    (code == `DSAIO_TRG_TIMER2);
  wire timer_hit  = is_timer & timer_match[code[1:0]];

  // Peripheral and pin events usable by short-address and block channels
  wire short_evt =
      timer_hit |
      ((code == `DSAIO_TRG_ADC)      & adc_conv_end) |
      ((code == `DSAIO_TRG_SER_TX)   & sci_tx_empty) |
      ((code == `DSAIO_TRG_SER_RX)   & sci_rx_full) |
      ((code == `DSAIO_TRG_EXT_EDGE) & ext_fall);
  wire block_evt =
      timer_hit |
      ((code == `DSAIO_TRG_ADC)      & adc_conv_end) |
      ((code == `DSAIO_TRG_EXT_EDGE) & ext_fall);
  wire norm_evt  = (code == `DSAIO_TRG_EXT_EDGE) & ext_fall;

  // One selected event per request, chosen by the three select bits
  assign trig_event = short_mode ? short_evt :
                      (mode == DSAIO_MODE_BLOCK) ? block_evt : norm_evt;
  assign trig_level = (code == `DSAIO_TRG_EXT_LEVEL) & ext_low &
                      (mode != DSAIO_MODE_BLOCK);
  // Auto-request needs no trigger at all once enabled
  assign auto_req   = (mode == DSAIO_MODE_NORMAL) &&
                      ((code == `DSAIO_TRG_AUTO_BURST) || (code == `DSAIO_TRG_AUTO_STEAL));
  assign auto_burst = (mode == DSAIO_MODE_NORMAL) && (code == `DSAIO_TRG_AUTO_BURST);

  // Receive-full and conversion-end move peripheral to memory
  assign periph_to_mem = short_mode &&
                         ((code == `DSAIO_TRG_SER_RX) || (code == `DSAIO_TRG_ADC));

  // Unusable codes start nothing
  assign code_ok = short_mode ? 1'b1 :
                   (mode == DSAIO_MODE_NORMAL) ? (auto_req || code[2:1] == 2'h3) :
                   (code[2] == 1'b0 || code == `DSAIO_TRG_EXT_EDGE);
endmodule

`default_nettype wire

// >>> design/dsaio_channel.sv
// Transfer channel engine: register port, trigger handling and bus sequencer.
// Assumes a single-master-at-a-time system bus with request/grant arbitration
// and a valid/ack handshake; peripheral events arrive as same-clock pulses.
//
// What this block does
// - Auto-request runs to count end, 24-bit addresses.
// - Cycle-steal releases bus after every transfer.
// - Burst holds bus unless higher master asks.
// - External request moves one unit each.
// - Block request moves block, restores one address.
// - Mode chosen per channel, independent of others.
// - I/O and idle move one unit per request.
// - Receive-full and conversion-end read peripheral.
// - I/O mode steps memory address each transfer.
// - Peripheral address low byte, high all ones.
// - Idle mode holds both addresses fixed.
// - Count down, clear enable, optional interrupt.
// - Idle completion always requests interrupt.
// - Start count zero means 65,536 transfers.
// - Timers, serial, converter, external triggers accepted.
// - Interrupt-enable plus repeat-enable selects idle.
// - Size bit picks byte or word transfers.
// - Three select bits choose activation source.
`include "dsaio_consts.svh"
`default_nettype none

module dsaio_channel (
  input  wire logic                       clock,
  input  wire logic                       rst,
  // Register port
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [31:0]                     reg_rdata,
  // Activation sources
  input  wire logic [2:0]                 timer_match,
  input  wire logic                       sci_tx_empty,
  input  wire logic                       sci_rx_full,
  input  wire logic                       adc_conv_end,
  input  wire logic                       ext_req_n,
  // System bus master
  output logic                            bus_req,
  input  wire logic                       bus_gnt,
  input  wire logic                       bus_preempt,
  output logic                            bus_valid,
  output logic                            bus_write,
  output logic                            bus_word,
  output logic [23:0]                     bus_addr,
  output logic [15:0]                     bus_wdata,
  input  wire logic [15:0]                bus_rdata,
  input  wire logic                       bus_ack,
  // Completion and mode
  output logic                            irq,
  output dsaio_pkg::dsaio_mode_type       active_mode
);
  import dsaio_pkg::*;

  // ========================================================================
  // Registers
  logic [23:0]     mem_addr_q,  mem_addr_d;   // Memory or source address
  logic [7:0]      periph_q,    periph_d;     // Peripheral address low byte
  logic [15:0]     count_q,     count_d;      // Transfer or block counter
  logic [7:0]      ctrl_q,      ctrl_d;       // Channel control
  logic [23:0]     dest_addr_q, dest_addr_d;  // Full-address destination
  logic [15:0]     full_q,      full_d;       // Full-address control
  logic            done_q,      done_d;       // Completion flag
  logic            pend_q,      pend_d;       // One outstanding request
  logic [8:0]      blk_left_q,  blk_left_d;   // Units left in this block
  logic [23:0]     blk_start_q, blk_start_d;  // Block-area start address
  logic [15:0]     data_q,      data_d;       // Word held between read and write
  logic [23:0]     addr_q,      addr_d;       // Bus address
  logic            write_q,     write_d;      // Bus cycle is a write
  logic [31:0]     rdata_q,     rdata_d;      // Register read data
  dsaio_state_type state_q,     state_d;      // Sequencer state

  // ========================================================================
  // Helpers
  // Step an address by one unit in the given direction
  function automatic logic [23:0] step_addr(input logic [23:0] a,
                                            input logic [1:0]  how,
                                            input logic        word);
    logic [23:0] unit;
    unit = word ? 24'h000002 : 24'h000001;
    case (how)
      `DSAIO_STEP_UP:   step_addr = a + unit;
      `DSAIO_STEP_DOWN: step_addr = a - unit;
      default:          step_addr = a;
    endcase
  endfunction

  // Pick the source or destination address of a transfer
  function automatic logic [23:0] pick_addr(input logic        short_m,
                                            input logic        p2m,
                                            input logic        want_src,
                                            input logic [23:0] mem,
                                            input logic [23:0] dst,
                                            input logic [7:0]  pa);
    logic [23:0] fixed;
    fixed = {`DSAIO_PERIPH_HIGH, pa};
    if (!short_m) begin
      pick_addr = want_src ? mem : dst;
    end else if (want_src) begin
      pick_addr = p2m ? fixed : mem;
    end else begin
      pick_addr = p2m ? mem : fixed;
    end
  endfunction

  // ========================================================================
  // Decoded control
  wire       te      = ctrl_q[`DSAIO_CTL_TE];
  wire       word    = ctrl_q[`DSAIO_CTL_SIZE];
  wire       dir_dn  = ctrl_q[`DSAIO_CTL_DIR];
  wire       irq_en  = ctrl_q[`DSAIO_CTL_IRQE];
  wire       rpt     = ctrl_q[`DSAIO_CTL_RPT];
  wire [2:0] code    = ctrl_q[`DSAIO_CTL_TRIG_HI:`DSAIO_CTL_TRIG_LO];
  wire       tms_src = full_q[`DSAIO_FC_TMS];
  wire [1:0] src_how = full_q[`DSAIO_FC_SRC_HI:`DSAIO_FC_SRC_LO];
  wire [1:0] dst_how = full_q[`DSAIO_FC_DST_HI:`DSAIO_FC_DST_LO];
  wire [7:0] blk_sz  = full_q[`DSAIO_FC_BSZ_HI:`DSAIO_FC_BSZ_LO];

  // Mode from this channel's own bits only, so channels differ freely
  assign active_mode = full_q[`DSAIO_FC_FULL] ?
                       (full_q[`DSAIO_FC_BLOCK] ? DSAIO_MODE_BLOCK : DSAIO_MODE_NORMAL) :
                       ((rpt & irq_en) ? DSAIO_MODE_IDLE : DSAIO_MODE_IO);

  wire short_m  = (active_mode == DSAIO_MODE_IO) || (active_mode == DSAIO_MODE_IDLE);
  wire block_m  = (active_mode == DSAIO_MODE_BLOCK);
  // Memory address walks in I/O mode, stands still in idle mode
  wire [1:0] mem_how = (active_mode == DSAIO_MODE_IDLE) ? `DSAIO_STEP_HOLD :
                       (dir_dn ? `DSAIO_STEP_DOWN : `DSAIO_STEP_UP);

  // ========================================================================
  // Trigger selection
  logic trig_event;  // Selected source fired
  logic trig_level;  // Level request held
  logic auto_req;    // Auto-request selected
  logic auto_burst;  // Auto-request in burst form
  logic p2m;         // Peripheral to memory direction
  logic code_ok;     // Select code is usable in this mode

  dsaio_trig_sel u_trig (
    .clock         (clock),
    .rst           (rst),
    .mode          (active_mode),
    .code          (code),
    .timer_match   (timer_match),
    .sci_tx_empty  (sci_tx_empty),
    .sci_rx_full   (sci_rx_full),
    .adc_conv_end  (adc_conv_end),
    .ext_req_n     (ext_req_n),
    .trig_event    (trig_event),
    .trig_level    (trig_level),
    .auto_req      (auto_req),
    .auto_burst    (auto_burst),
    .periph_to_mem (p2m),
    .code_ok       (code_ok)
  );

  // ========================================================================
  // Sequencer decode
  wire in_idle   = (state_q == DSAIO_ST_IDLE);
  wire want_go   = te & code_ok & (auto_req | pend_q | trig_level);
  wire start     = in_idle & want_go;
  wire wr_done   = (state_q == DSAIO_ST_WR) & bus_ack;
  // A block opens on the first unit after a request
  wire blk_open  = start & block_m & (blk_left_q == 9'h000);
  wire [8:0] blk_full = (blk_sz == 8'h00) ? 9'h100 : {1'b0, blk_sz};
  wire [8:0] blk_now  = blk_open ? blk_full : blk_left_q;

  // Counter wraps from zero to all ones, giving 65,536 units
  wire [15:0] count_dec = count_q - 16'h0001;
  wire        blk_end   = block_m & (blk_left_q == 9'h001);
  wire        cnt_tick  = wr_done & (~block_m | blk_end);
  wire        finish    = cnt_tick & (count_dec == 16'h0000);
  wire        blk_more  = block_m & (blk_left_q > 9'h001);
  // Burst keeps the bus while granted and nobody higher asks
  wire        keep_bus  = ~finish & ~bus_preempt & bus_gnt &
                          (blk_more | (auto_burst & te));

  // Next addresses after this unit lands
  wire [23:0] mem_step  = step_addr(mem_addr_q, short_m ? mem_how : src_how, word);
  wire [23:0] dst_step  = step_addr(dest_addr_q, dst_how, word);
  wire [23:0] mem_nx    = (blk_end & tms_src) ? blk_start_q : mem_step;
  wire [23:0] dst_nx    = (blk_end & ~tms_src) ? blk_start_q : dst_step;
  wire [23:0] src_now   = pick_addr(short_m, p2m, 1'b1, mem_addr_q, dest_addr_q, periph_q);
  wire [23:0] dst_now   = pick_addr(short_m, p2m, 1'b0, mem_addr_q, dest_addr_q, periph_q);
  wire [23:0] src_next  = pick_addr(short_m, p2m, 1'b1, mem_nx, dst_nx, periph_q);

  // Register port decode
  wire wr_mem   = reg_wr & (reg_addr == `DSAIO_REG_MEM_ADDR);
  wire wr_per   = reg_wr & (reg_addr == `DSAIO_REG_PERIPH_LO);
  wire wr_cnt   = reg_wr & (reg_addr == `DSAIO_REG_COUNT);
  wire wr_ctl   = reg_wr & (reg_addr == `DSAIO_REG_CTRL);
  wire wr_dst   = reg_wr & (reg_addr == `DSAIO_REG_DEST_ADDR);
  wire wr_full  = reg_wr & (reg_addr == `DSAIO_REG_FULL_CTRL);
  wire wr_stat  = reg_wr & (reg_addr == `DSAIO_REG_STATUS);

  // ========================================================================
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    write_d = write_q;
    data_d  = data_q;
    case (state_q)
      // Wait for something to do
      DSAIO_ST_IDLE: begin
        if (start) begin
          state_d = DSAIO_ST_REQ;
        end
      end
      // Bus requested, wait for the grant
      DSAIO_ST_REQ: begin
        if (bus_gnt) begin
          state_d = DSAIO_ST_RD;
          addr_d  = src_now;
          write_d = 1'b0;
        end
      end
      // Read the source
      DSAIO_ST_RD: begin
        if (bus_ack) begin
          state_d = DSAIO_ST_WR;
          data_d  = word ? bus_rdata : {8'h00, bus_rdata[7:0]};
          addr_d  = dst_now;
          write_d = 1'b1;
        end
      end
      // Write the destination, then hold or give back the bus
      DSAIO_ST_WR: begin
        if (bus_ack) begin
          if (keep_bus) begin
            state_d = DSAIO_ST_RD;
            addr_d  = src_next;
            write_d = 1'b0;
          end else begin
            state_d = DSAIO_ST_IDLE;
          end
        end
      end
      default: begin
        state_d = DSAIO_ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // Register and counter next values
  always_comb begin
    mem_addr_d  = wr_mem  ? reg_wdata[23:0] : mem_addr_q;
    periph_d    = wr_per  ? reg_wdata[7:0]  : periph_q;
    count_d     = wr_cnt  ? reg_wdata[15:0] : count_q;
    ctrl_d      = wr_ctl  ? reg_wdata[7:0]  : ctrl_q;
    dest_addr_d = wr_dst  ? reg_wdata[23:0] : dest_addr_q;
    full_d      = wr_full ? reg_wdata[15:0] : full_q;
    blk_left_d  = blk_now;
    blk_start_d = blk_start_q;
    // Hardware updates win over a write in the same cycle
    if (blk_open) begin
      blk_start_d = tms_src ? mem_addr_q : dest_addr_q;
    end
    if (wr_done) begin
      mem_addr_d  = mem_nx;
      dest_addr_d = dst_nx;
      blk_left_d  = block_m ? blk_left_q - 9'h001 : 9'h000;
    end
    if (cnt_tick) begin
      count_d = count_dec;
    end
    if (finish) begin
      ctrl_d[`DSAIO_CTL_TE] = 1'b0;
    end
    if (~te) begin
      blk_left_d = 9'h000;
    end
  end

  // Completion flag: set wins over software clear
  assign done_d = finish | (done_q & ~(wr_ctl | (wr_stat & reg_wdata[1])));
  // Pending request: one per event, block takes one per block
  wire take = start & ~auto_req & ~trig_level & (~block_m | blk_open);
  assign pend_d = te & ((pend_q & ~take) | trig_event);

  // Register read mux, unmapped reads give zero
  always_comb begin
    case (reg_addr)
      `DSAIO_REG_MEM_ADDR:  rdata_d = {8'h00, mem_addr_q};
      `DSAIO_REG_PERIPH_LO: rdata_d = {24'h000000, periph_q};
      `DSAIO_REG_COUNT:     rdata_d = {16'h0000, count_q};
      `DSAIO_REG_CTRL:      rdata_d = {24'h000000, ctrl_q};
      `DSAIO_REG_DEST_ADDR: rdata_d = {8'h00, dest_addr_q};
      `DSAIO_REG_FULL_CTRL: rdata_d = {16'h0000, full_q};
      `DSAIO_REG_STATUS:    rdata_d = {14'h0000, blk_left_q, 4'h0,
                                       active_mode, pend_q, done_q, ~in_idle};
      default:              rdata_d = 32'h00000000;
    endcase
    if (!reg_rd) begin
      rdata_d = 32'h00000000;
    end
  end

  // ========================================================================
  // Flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_addr_q  <= `DSAIO_RST_ADDR;
      periph_q    <= `DSAIO_RST_PERIPH;
      count_q     <= `DSAIO_RST_COUNT;
      ctrl_q      <= `DSAIO_RST_CTRL;
      dest_addr_q <= `DSAIO_RST_ADDR;
      full_q      <= `DSAIO_RST_FULL_CTRL;
      done_q      <= 1'b0;
      pend_q      <= 1'b0;
      blk_left_q  <= 9'h000;
      blk_start_q <= `DSAIO_RST_ADDR;
    end else begin
      mem_addr_q  <= mem_addr_d;
      periph_q    <= periph_d;
      count_q     <= count_d;
      ctrl_q      <= ctrl_d;
      dest_addr_q <= dest_addr_d;
      full_q      <= full_d;
      done_q      <= done_d;
      pend_q      <= pend_d;
      blk_left_q  <= blk_left_d;
      blk_start_q <= blk_start_d;
    end
  end

  // Bus-side flops and read data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= DSAIO_ST_IDLE;
      addr_q  <= `DSAIO_RST_ADDR;
      write_q <= 1'b0;
      data_q  <= 16'h0000;
      rdata_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
      write_q <= write_d;
      data_q  <= data_d;
      rdata_q <= rdata_d;
    end
  end

  // ========================================================================
  // Outputs
  // Request drops in idle, so cycle-steal gives the bus back each unit
  assign bus_req   = ~in_idle;
  assign bus_valid = (state_q == DSAIO_ST_RD) || (state_q == DSAIO_ST_WR);
  assign bus_write = write_q;
  assign bus_word  = word;
  assign bus_addr  = addr_q;
  assign bus_wdata = data_q;
  assign reg_rdata = rdata_q;
  // Interrupt while completion stands and enabled; idle mode has it enabled
  assign irq       = done_q & irq_en;
endmodule

`default_nettype wire

// >>> tb/dsaio_channel_assertions.sv
// Port-level checker for the transfer channel.
// Assumes it is bound to dsaio_channel from the testbench top file.
`default_nettype none
module dsaio_channel_chk (
  input wire logic                      clock,
  input wire logic                      rst,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire logic                      bus_req,
  input wire logic                      bus_gnt,
  input wire logic                      bus_valid,
  input wire logic                      bus_write,
  input wire logic                      bus_word,
  input wire logic [23:0]               bus_addr,
  input wire logic [15:0]               bus_wdata,
  input wire logic                      bus_ack,
  input wire logic                      irq,
  input wire dsaio_pkg::dsaio_mode_type active_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsaio_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ========================================================================
  // Steps of one unit: read acknowledged, then write acknowledged
  sequence rd_ack; bus_valid && !bus_write && bus_ack; endsequence
  sequence wr_ack; bus_valid && bus_write && bus_ack; endsequence
  valid_owns_bus_a: assert property (bus_valid |-> bus_req) else $error("cycle without bus");
  grant_start_a: assert property (bus_req && !bus_valid && bus_gnt |=> bus_valid && !bus_write)
    else $error("no read after grant");
  cycle_hold_a: assert property (bus_valid && !bus_ack |=> bus_valid && $stable(bus_addr))
    else $error("cycle dropped early");
  read_then_write_a: assert property (rd_ack |=> bus_valid && bus_write) else $error("no write");
  unit_release_a: assert property (wr_ack ##0 (active_mode inside {DSAIO_MODE_IO, DSAIO_MODE_IDLE})
    |=> !bus_req) else $error("bus kept after unit");
  irq_cause_a: assert property ($rose(irq) |-> $past(bus_valid && bus_write && bus_ack))
    else $error("irq without completion");
  byte_lane_a: assert property (bus_valid && bus_write && !bus_word |-> bus_wdata[15:8] == 8'h00)
    else $error("byte upper lane");
  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata");
endmodule
`default_nettype wire

// >>> tb/dsaio_bus_model.sv
// Bus slave and arbiter standing in for memory and peripherals.
// Assumes the channel holds each cycle until acknowledged.
`default_nettype none
module dsaio_bus_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        bus_req,
  input  wire logic        bus_valid,
  input  wire logic [23:0] bus_addr,
  output logic             bus_gnt,
  output logic             bus_ack,
  output logic [15:0]      bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Grant one cycle late; ack one cycle late; data scrambles outside ack
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_gnt <= 1'b0;
      bus_ack <= 1'b0;
      bus_rdata <= 16'h0000;
    end else begin
      bus_gnt <= bus_req;
      bus_ack <= bus_valid && !bus_ack;
      bus_rdata <= (bus_valid && !bus_ack) ? (bus_addr[15:0] ^ 16'h5a5a) : ~bus_rdata;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Top bench: register tasks, trigger pulses and a bus monitor.
// Assumes the bus model answers every cycle.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dsaio_pkg::*;
  logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, tx = 0, rx = 0, word = 0;
  logic bus_req, bus_gnt, bus_valid, bus_write, bus_word, bus_ack, irq;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [23:0] bus_addr, src, dst;
  logic [15:0] bus_wdata, bus_rdata, e;
  dsaio_mode_type active_mode;
  int failures = 0, n_checks = 0, spin;
  always #20 clock = ~clock;
  dsaio_channel dsaio_channel_i (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_match({3{tx}}), .sci_tx_empty(tx), .sci_rx_full(rx), .adc_conv_end(rx),
    .ext_req_n(1'b1), .bus_req(bus_req), .bus_gnt(bus_gnt), .bus_preempt(1'b0),
    .bus_valid(bus_valid), .bus_write(bus_write), .bus_word(bus_word), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .irq(irq),
    .active_mode(active_mode));
  dsaio_bus_model dsaio_bus_model_i (.clock(clock), .rst(rst), .bus_req(bus_req),
    .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_gnt(bus_gnt), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    @(posedge clock); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock); reg_rd <= 1'b0;
    #1 chk("reg", reg_rdata, x);
  endtask
  // One trigger pulse, then wait for the write of the unit to finish
  task automatic go(input logic r);
    @(posedge clock); if (r) rx <= 1'b1; else tx <= 1'b1;
    @(posedge clock); rx <= 1'b0; tx <= 1'b0;
    for (spin = 0; spin < 30 && !(bus_valid && bus_write && bus_ack); spin++) @(posedge clock);
    chk("unit", spin < 30, 1'b1);
    repeat (2) @(posedge clock);
  endtask
  // Every acknowledged cycle is compared with the expected address, each write also with the data
  always @(posedge clock) if (bus_valid && bus_ack) begin
    e = src[15:0] ^ 16'h5a5a;
    if (!bus_write) chk("src", {8'h0, bus_addr}, {8'h0, src});
    else begin
      chk("dst", {8'h0, bus_addr}, {8'h0, dst});
      chk("data", {16'h0, bus_wdata}, {16'h0, word ? e : {8'h00, e[7:0]}});
    end
  end
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100us failures++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // Byte, incrementing, transmit-empty trigger, two units, irq enabled
    wr(4'h0, 32'h001000); wr(4'h1, 32'h40); wr(4'h2, 32'h2); wr(4'h3, 32'h8c);
    src = 24'h001000; dst = 24'hffff40; go(0);
    src = 24'h001001; go(0);
    rd(4'h0, 32'h001002);
    rd(4'h2, 32'h0);
    rd(4'h3, 32'h0c);
    chk("irq", irq, 1'b1);
    // Word, decrementing, receive-full trigger reads the peripheral, no irq
    word = 1; wr(4'h0, 32'h002000); wr(4'h2, 32'h1); wr(4'h3, 32'he5);
    src = 24'hffff40; dst = 24'h002000; go(1);
    rd(4'h0, 32'h001ffe);
    chk("irq", irq, 1'b0);
    // Idle mode holds the memory address and always interrupts
    word = 0; wr(4'h0, 32'h003000); wr(4'h2, 32'h1); wr(4'h3, 32'h98);
    #1 chk("mode", active_mode, DSAIO_MODE_IDLE);
    src = 24'h003000; dst = 24'hffff40; go(0);
    rd(4'h0, 32'h003000);
    chk("irq", irq, 1'b1);
    // Zero start count wraps to the top, unmapped index reads zero
    wr(4'h0, 32'h004000); wr(4'h2, 32'h0); wr(4'h3, 32'h83);
    src = 24'hffff40; dst = 24'h004000; go(1);
    rd(4'h2, 32'hffff);
    rd(4'hf, 32'h0);
    summarize();
  end
endmodule
bind dsaio_channel dsaio_channel_chk dsaio_channel_chk_i (.clock(clock), .rst(rst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req), .bus_gnt(bus_gnt),
  .bus_valid(bus_valid), .bus_write(bus_write), .bus_word(bus_word), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_ack(bus_ack), .irq(irq), .active_mode(active_mode));
`default_nettype wire
